// [ets_pkg.sv]
// Package with constants and types for the error and thermal signalling block
package ets_pkg;

  // Machine check pulse length in base clock cycles
  localparam int unsigned MCE_HOLD_CYCLES = 16;
  localparam int unsigned MCE_CNT_W       = 5;
  // Thermal trip threshold in degrees Celsius
  localparam int unsigned TRIP_TEMP_C     = 130;
  localparam int unsigned TEMP_W          = 8;
  localparam logic [TEMP_W-1:0] TRIP_TEMP = TRIP_TEMP_C[TEMP_W-1:0];

  // Fatal error sequencer states
  typedef enum logic [1:0] {
    ETS_FE_IDLE  = 2'b00,
    ETS_FE_PULSE = 2'b01,
    ETS_FE_HOLD  = 2'b10
  } ets_fe_state_e;

  // Error events from the core
  typedef struct packed {
    logic machine_check_error;
    logic internal_error;
  } ets_err_s;

  // Thermal sensor report
  typedef struct packed {
    logic              at_max_temp;
    logic [TEMP_W-1:0] junction_temp;
  } ets_sensor_s;

endpackage : ets_pkg

// [ets_fatal_seq.sv]
// Fatal error output sequencer: timed pulse or held assertion
`timescale 1ns/1ns
module ets_fatal_seq
  import ets_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = MCE_HOLD_CYCLES
) (
  input  wire logic     core_clk,
  input  wire logic     reset_n,
  input  wire logic     warm_reset,
  input  wire ets_err_s err,
  output logic          fatal_active
);

  ets_fe_state_e        state_reg;
  ets_fe_state_e        state_next;
  logic [MCE_CNT_W-1:0] cnt_reg;
  logic [MCE_CNT_W-1:0] cnt_next;

  localparam logic [MCE_CNT_W-1:0] LAST_CNT = MCE_CNT_W'(HOLD_CYCLES - 1);

  // Internal error wins over a machine check since it never releases
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ETS_FE_IDLE: begin
        if (err.internal_error) begin
          state_next = ETS_FE_HOLD;
        end else if (err.machine_check_error) begin
          state_next = ETS_FE_PULSE;
          cnt_next   = '0;
        end
      end
      ETS_FE_PULSE: begin
        if (err.internal_error) begin
          state_next = ETS_FE_HOLD;
        end else if (cnt_reg == LAST_CNT) begin
          state_next = ETS_FE_IDLE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ETS_FE_HOLD: state_next = ETS_FE_HOLD;
      default:     state_next = ETS_FE_IDLE;
    endcase
  end

  // Warm reset clears the held indication as a cold reset does
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ETS_FE_IDLE;
      cnt_reg   <= '0;
    end else if (warm_reset) begin
      state_reg <= ETS_FE_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign fatal_active = (state_reg != ETS_FE_IDLE);

endmodule : ets_fatal_seq

// [ets_top.sv]
// Error and thermal protection signalling logic of the device
`timescale 1ns/1ns
module ets_top
  import ets_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        warm_reset,
  input  wire ets_err_s    err,
  input  wire ets_sensor_s sensor,
  input  wire logic        tcc_enable,
  input  wire logic        overheat_flag_n_in,
  output logic             fatal_error_n,
  output logic             fatal_error_n_oe,
  output logic             overheat_flag_n,
  output logic             overheat_flag_n_oe,
  output logic             thermal_shutdown_n,
  output logic             thermal_shutdown_n_oe,
  output logic             thermal_control_circuit,
  output logic             exec_halt
);

  // Position of each open-drain line in the per-line vectors below
  localparam int unsigned PIN_FATAL = 0;
  localparam int unsigned PIN_HOT   = 1;
  localparam int unsigned PIN_TRIP  = 2;
  localparam int unsigned PIN_COUNT = 3;

  // Fatal sequencer result, high while the fatal line must be pulled
  logic                 fatal_active;

  // Overheat pin synchroniser; the board may move the line at any time
  logic                 oh_sync1_reg;
  logic                 oh_sync1_next;
  logic                 oh_sync2_reg;
  logic                 oh_sync2_next;

  // Registered drive request for our own overheat pull
  logic                 oh_drive_reg;
  logic                 oh_drive_next;

  // Registered control circuit state
  logic                 tcc_reg;
  logic                 tcc_next;

  // Sticky thermal trip state
  logic                 trip_reg;
  logic                 trip_next;

  // Registered fatal pull request
  logic                 fatal_reg;
  logic                 fatal_next;

  // Decoded overheat and trip conditions
  logic                 own_hot;
  logic                 ext_hot;
  logic                 any_hot;
  logic                 trip_hit;

  // One bit per open-drain line
  logic [PIN_COUNT-1:0] pull_req;
  logic [PIN_COUNT-1:0] pin_val;
  logic [PIN_COUNT-1:0] pin_oe;

  ets_fatal_seq #(
    .HOLD_CYCLES (MCE_HOLD_CYCLES)
  ) u_fatal (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .warm_reset   (warm_reset),
    .err          (err),
    .fatal_active (fatal_active)
  );

  // Synchroniser inputs: the pin enters the first stage only
  assign oh_sync1_next = overheat_flag_n_in;
  assign oh_sync2_next = oh_sync1_reg;

  // First synchroniser stage; resets to the released level so that no
  // false overheat is seen while the line settles after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oh_sync1_reg <= 1'b1;
    end else begin
      oh_sync1_reg <= oh_sync1_next;
    end
  end

  // Second synchroniser stage; the only stage that logic reads
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oh_sync2_reg <= 1'b1;
    end else begin
      oh_sync2_reg <= oh_sync2_next;
    end
  end

  // Overheat sources: our own sensor or the board pulling the line.
  // Our own pull also shows on the pin; it only feeds the control
  // circuit and never our own drive, so the line cannot latch itself
  assign own_hot  = sensor.at_max_temp;
  assign ext_hot  = ~oh_sync2_reg;
  assign any_hot  = own_hot | ext_hot;

  // Trip is strictly above the threshold; equal is still safe
  assign trip_hit = (sensor.junction_temp > TRIP_TEMP);

  // Next values of the drive and control registers
  assign oh_drive_next = own_hot;
  assign tcc_next      = tcc_enable & any_hot;
  assign trip_next     = trip_reg | trip_hit;
  assign fatal_next    = fatal_active;

  // Overheat drive follows the sensor and is not sticky
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oh_drive_reg <= 1'b0;
    end else begin
      oh_drive_reg <= oh_drive_next;
    end
  end

  // Control circuit engages only while it is enabled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tcc_reg <= 1'b0;
    end else begin
      tcc_reg <= tcc_next;
    end
  end

  // Thermal trip latches until cold reset: a warm reset must not let an
  // overheated core resume execution
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trip_reg <= 1'b0;
    end else begin
      trip_reg <= trip_next;
    end
  end

  // Fatal request is registered so the pin only moves on a clock edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fatal_reg <= 1'b0;
    end else begin
      fatal_reg <= fatal_next;
    end
  end

  // Pull requests gathered per line
  assign pull_req[PIN_FATAL] = fatal_reg;
  assign pull_req[PIN_HOT]   = oh_drive_reg;
  assign pull_req[PIN_TRIP]  = trip_reg;

  // Open-drain lines: value always low, enable low while pulling the pin;
  // the board pull-up gives the released level
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    assign pin_val[i] = 1'b0;
    assign pin_oe[i]  = ~pull_req[i];
  end

  // Fatal error line
  assign fatal_error_n    = pin_val[PIN_FATAL];
  assign fatal_error_n_oe = pin_oe[PIN_FATAL];

  // Overheat line
  assign overheat_flag_n    = pin_val[PIN_HOT];
  assign overheat_flag_n_oe = pin_oe[PIN_HOT];

  // Thermal shutdown line
  assign thermal_shutdown_n    = pin_val[PIN_TRIP];
  assign thermal_shutdown_n_oe = pin_oe[PIN_TRIP];

  // Core-side status
  assign thermal_control_circuit = tcc_reg;
  assign exec_halt               = trip_reg;

endmodule : ets_top

// [ets_board.sv]
// Board model: pulled-up overheat line
`timescale 1ns/1ns
module ets_board (
  input wire logic oh_n,
  input wire logic oh_oe,
  input wire logic ext_hot,
  output logic wire_n
);
  // Pull-up wins unless a party sinks the line
  assign wire_n = (oh_oe | oh_n) & !ext_hot;
endmodule : ets_board

// [ets_chk_sva.sv]
// Port checker for the error and thermal block
`timescale 1ns/1ns
module ets_chk
  import ets_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic warm_reset,
  input wire ets_err_s err,
  input wire ets_sensor_s sensor,
  input wire logic tcc_enable,
  input wire logic overheat_flag_n_in,
  input wire logic fatal_error_n_oe,
  input wire logic overheat_flag_n_oe,
  input wire logic thermal_shutdown_n_oe,
  input wire logic thermal_control_circuit,
  input wire logic exec_halt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] low_cnt;
  // Low run length, read on release
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) low_cnt <= 5'h0;
    else low_cnt <= fatal_error_n_oe ? 5'h0 : low_cnt + 5'h1;
  a_mce_start:
    assert property (err.machine_check_error && fatal_error_n_oe && !warm_reset && !$past(err)
      |-> ##2 !fatal_error_n_oe) else $error("no fatal");
  a_mce_width:
    assert property ($rose(fatal_error_n_oe) && !$past(warm_reset) && !$past(warm_reset, 2)
      |-> low_cnt == 5'h10) else $error("bad width");
  a_internal_error_hold:
    assert property (err.internal_error && !warm_reset |-> ##2 !fatal_error_n_oe)
      else $error("no hold");
  a_hot_drive:
    assert property (sensor.at_max_temp |=> !overheat_flag_n_oe &&
      thermal_control_circuit == $past(tcc_enable)) else $error("no hot");
  a_ext_hot:
    assert property ((tcc_enable && !overheat_flag_n_in) [*4] |-> thermal_control_circuit)
      else $error("ext lost");
  a_trip_set:
    assert property (sensor.junction_temp > TRIP_TEMP |=> !thermal_shutdown_n_oe && exec_halt)
      else $error("no trip");
  a_hot_free:
    assert property (!sensor.at_max_temp |=> overheat_flag_n_oe) else $error("stuck");
endmodule : ets_chk
bind ets_top ets_chk chk_u (.*);

// [error_thermal_signaling_bench.sv]
// Bench for the error and thermal block
`timescale 1ns/1ns
module error_thermal_signaling_bench;
  import ets_pkg::*;
  logic core_clk = 0, reset_n = 0, warm_reset = 0, tcc_enable = 0, ext_hot = 0, hot_n;
  logic fatal_error_n, fatal_error_n_oe, overheat_flag_n, overheat_flag_n_oe;
  logic thermal_shutdown_n, thermal_shutdown_n_oe, thermal_control_circuit, exec_halt;
  ets_err_s err = '0;
  ets_sensor_s sensor = '0;
  int errors = 0, n_tests = 0, k;
  ets_top dut_u (.*, .overheat_flag_n_in(hot_n));
  ets_board brd_u (.oh_n(overheat_flag_n), .oh_oe(overheat_flag_n_oe), .ext_hot, .wire_n(hot_n));
  initial forever #4 core_clk = ~core_clk;
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask : w
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %h %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Timed pulse then held error cleared by warm reset
  task automatic fatal;
    err = 2'h2;
    w(1);
    err = 2'h0;
    k = 0;
    repeat (40) @(negedge core_clk) k += !fatal_error_n_oe;
    chk(k, 8'h10);
    err = 2'h1;
    w(1);
    err = 2'h0;
    w(40);
    chk({fatal_error_n_oe, fatal_error_n}, 8'h0);
    warm_reset = 1'h1;
    w(1);
    warm_reset = 1'h0;
    w(3);
    chk(fatal_error_n_oe, 8'h1);
  endtask : fatal
  // Own overheat, then board-driven overheat, then trip at the boundary
  task automatic thermal;
    tcc_enable = 1'h1;
    sensor = {1'h1, TRIP_TEMP};
    w(2);
    chk({hot_n, thermal_control_circuit, thermal_shutdown_n_oe}, 8'h3);
    sensor.at_max_temp = 1'h0;
    ext_hot = 1'h1;
    w(5);
    chk({overheat_flag_n_oe, thermal_control_circuit}, 8'h3);
    tcc_enable = 1'h0;
    sensor.at_max_temp = 1'h1;
    w(2);
    chk({overheat_flag_n_oe, thermal_control_circuit}, 8'h0);
    sensor.junction_temp = TRIP_TEMP + 8'h01;
    w(2);
    sensor.junction_temp = 8'h00;
    w(2);
    chk({thermal_shutdown_n_oe, thermal_shutdown_n, exec_halt}, 8'h1);
  endtask : thermal
  initial begin
    w(10);
    reset_n = 1'h1;
    fatal;
    fatal;
    thermal;
    summarize;
  end
  // Cut a hang short
  initial begin
    #20000 errors++;
    summarize;
  end
endmodule : error_thermal_signaling_bench
